// File: include/rtc_dst_map.svh
// Purpose: constants for the daylight-saving adjust block
// Assumes: offsets are serial-bus word addresses of the RTC space
// Notes:   shared by the register file and the transition matchers
//
// Summary of operation
// - When enabled, step time forward and back at programmed moments unaided.
// - Transition settings repeat every year without being reprogrammed.
// - Enable bit is bit 7 of forward month; April enabled reads 84h.
// - Week/day register holds select, week and weekday; week 1 Sunday is 48h.
// - Hour and month are plain BCD; hour ignores 12/24h format bit.
// - Week code 7 fires on the last such weekday of the month.
// - Forward-applied flag goes to 1 after the forward step.
// - Flag clears on reverse step, power-up, or enable written to 0.
// - Forward-applied flag is readable in the status register.
// - Flag is read-only; setting time never raises it.
`ifndef RTC_DST_MAP_SVH
`define RTC_DST_MAP_SVH

`define DST_FWD_MONTH_OFS  8'h15
`define DST_FWD_WDAY_OFS   8'h16
`define DST_FWD_DATE_OFS   8'h17
`define DST_FWD_HOUR_OFS   8'h18
`define DST_REV_MONTH_OFS  8'h19
`define DST_REV_WDAY_OFS   8'h1A
`define DST_REV_DATE_OFS   8'h1B
`define DST_REV_HOUR_OFS   8'h1C
`define DST_STATUS_OFS     8'h01
`define DST_PTR_LAST       8'h2F
`define DST_DEV_ADDR       7'h6F

`define DST_REG_COUNT      8
`define DST_REG_RESET      8'h00
`define DST_FLAG_BIT       5
`define DST_ENABLE_BIT     7
`define DST_SELECT_BIT     6
`define DST_WEEK_MSB       5
`define DST_WEEK_LSB       3
`define DST_DAY_MSB        2
`define DST_WEEK_LAST      3'h7
`define DST_HOUR_MASK      8'h3F
`define DST_MONTH_MASK     8'h1F
`define DST_DATE_MASK      8'h3F
`define DST_BIT_LAST       4'h8
`define DST_BIT_RD_LAST    4'h7

`endif

// File: include/rtc_dst_pkg.sv
// Purpose: types for the daylight-saving adjust block
// Assumes: nothing
// Notes:   serial slave states follow a Gray path
package rtc_dst_pkg;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_DEV      = 4'h1,
    ST_ACK_DEV  = 4'h3,
    ST_WADDR    = 4'h2,
    ST_ACK_ADDR = 4'h6,
    ST_WDATA    = 4'h7,
    ST_ACK_WR   = 4'h5,
    ST_RDATA    = 4'h4,
    ST_RACK     = 4'hC
  } slave_state_t;

endpackage : rtc_dst_pkg

// File: include/time_now_if.sv
// Purpose: current calendar time as seen by the transition matchers
// Assumes: all fields BCD, hour in 24-hour form, weekday 0 = Sunday
// Notes:   driven by the top, read by each matcher
`timescale 1ns/1ps
interface time_now_if;
  logic [7:0] year;
  logic [7:0] month;
  logic [7:0] date;
  logic [2:0] wday;
  logic [7:0] hour;
  modport src  (output year, month, date, wday, hour);
  modport sink (input  year, month, date, wday, hour);
endinterface : time_now_if

// File: hw/dst_match.sv
// Purpose: decides whether now is one programmed transition moment
// Assumes: time fields are BCD and valid
// Notes:   minute and second alignment is checked by the caller
`timescale 1ns/1ps
`include "rtc_dst_map.svh"
module dst_match (
  time_now_if.sink  now,
  input  wire logic [7:0] month_i,
  input  wire logic [7:0] wday_i,
  input  wire logic [7:0] date_i,
  input  wire logic [7:0] hour_i,
  output logic            hit_o
);

  function automatic logic [6:0] bcd2bin(input logic [7:0] b);
    bcd2bin = 7'(b[7:4]) * 7'd10 + 7'(b[3:0]);
  endfunction : bcd2bin

  function automatic logic [4:0] days_in(input logic [6:0] m,
                                         input logic [6:0] y);
    logic [4:0] n;
    n = 5'd31;
    if (m == 7'd4 || m == 7'd6 || m == 7'd9 || m == 7'd11) begin
      n = 5'd30;
    end else if (m == 7'd2) begin
      n = (y[1:0] == 2'b00) ? 5'd29 : 5'd28;
    end
    days_in = n;
  endfunction : days_in

  logic [6:0] day_bin;
  logic [2:0] week_now;
  logic       last_now;
  logic       day_ok;

  always_comb begin
    day_bin  = bcd2bin(now.date);
    week_now = 3'(7'(day_bin - 7'd1) / 7'd7 + 7'd1);
    last_now = (day_bin + 7'd7) >
               7'(days_in(bcd2bin(now.month), bcd2bin(now.year)));
    if (wday_i[`DST_SELECT_BIT]) begin
      day_ok = (wday_i[`DST_DAY_MSB:0] == now.wday) &&
               ((wday_i[`DST_WEEK_MSB:`DST_WEEK_LSB] ==
                 `DST_WEEK_LAST) ? last_now :
                (wday_i[`DST_WEEK_MSB:`DST_WEEK_LSB] == week_now));
    end else begin
      day_ok = ((date_i & `DST_DATE_MASK) == now.date);
    end
    // year is not compared, so the setting recurs yearly
    hit_o = day_ok &&
            ((month_i & `DST_MONTH_MASK) == now.month) &&
            ((hour_i & `DST_HOUR_MASK) == now.hour);
  end

endmodule : dst_match

// File: hw/rtc_daylight_saving_adjust.sv
// Purpose: daylight-saving registers, two-wire slave and auto adjust
// Assumes: time inputs on clk_sys_i; tick_i marks each new second
// Notes:   hour_fwd_o / hour_back_o ask the clock core for one-hour steps
`timescale 1ns/1ps
`include "rtc_dst_map.svh"
module rtc_daylight_saving_adjust (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic       tick_i,
  input  wire logic [7:0] year_i,
  input  wire logic [7:0] month_i,
  input  wire logic [7:0] date_i,
  input  wire logic [2:0] wday_i,
  input  wire logic [7:0] hour_i,
  input  wire logic [7:0] minute_i,
  input  wire logic [7:0] second_i,
  output logic            hour_fwd_o,
  output logic            hour_back_o,
  output logic            forward_applied_o
);

  // pin synchronisers
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_comb begin
    scl_rise  = scl_s2_q & ~scl_s3_q;
    scl_fall  = ~scl_s2_q & scl_s3_q;
    bus_start = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
    bus_stop  = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;
  end

  // configuration registers and forward-applied flag
  logic [7:0] cfg_q [`DST_REG_COUNT];
  logic [7:0] cfg_d [`DST_REG_COUNT];
  logic       flag_q, flag_d;

  function automatic logic in_window(input logic [7:0] a);
    in_window = (a >= `DST_FWD_MONTH_OFS) && (a <= `DST_REV_HOUR_OFS);
  endfunction : in_window

  function automatic logic [2:0] win_index(input logic [7:0] a);
    win_index = 3'(a - `DST_FWD_MONTH_OFS);
  endfunction : win_index

  function automatic logic [7:0] ptr_next(input logic [7:0] a);
    ptr_next = (a >= `DST_PTR_LAST) ? 8'h00 : 8'(a + 8'h01);
  endfunction : ptr_next

  function automatic logic [7:0] read_byte(input logic [7:0] a,
                                           input logic [7:0] v,
                                           input logic       f);
    logic [7:0] r;
    r = 8'h00;
    if (a == `DST_STATUS_OFS) begin
      r[`DST_FLAG_BIT] = f;
    end else if (in_window(a)) begin
      r = v;
    end
    read_byte = r;
  endfunction : read_byte

  // serial slave
  rtc_dst_pkg::slave_state_t st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] ptr_q, ptr_d;
  logic       rw_q, rw_d;
  logic       oe_q, oe_d;
  logic       nack_q, nack_d;
  logic       wr_q, wr_d;
  logic [7:0] wa_q, wa_d;
  logic [7:0] wd_q, wd_d;
  logic [7:0] rd_now, rd_nxt;

  always_comb begin
    rd_now = read_byte(ptr_q, cfg_q[win_index(ptr_q)], flag_q);
    rd_nxt = read_byte(ptr_next(ptr_q),
                       cfg_q[win_index(ptr_next(ptr_q))], flag_q);
  end

  always_comb begin
    st_d   = st_q;
    bit_d  = bit_q;
    sh_d   = sh_q;
    ptr_d  = ptr_q;
    rw_d   = rw_q;
    oe_d   = oe_q;
    nack_d = nack_q;
    wr_d   = 1'b0;
    wa_d   = wa_q;
    wd_d   = wd_q;
    if (bus_start) begin
      st_d  = rtc_dst_pkg::ST_DEV;
      bit_d = 4'h0;
      oe_d  = 1'b0;
    end else if (bus_stop) begin
      st_d = rtc_dst_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        rtc_dst_pkg::ST_IDLE: begin
        end
        rtc_dst_pkg::ST_DEV, rtc_dst_pkg::ST_WADDR,
        rtc_dst_pkg::ST_WDATA: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s2_q};
            bit_d = 4'(bit_q + 4'h1);
          end else if (scl_fall && bit_q == `DST_BIT_LAST) begin
            oe_d = 1'b1;
            if (st_q == rtc_dst_pkg::ST_DEV) begin
              if (sh_q[7:1] == `DST_DEV_ADDR) begin
                rw_d = sh_q[0];
                st_d = rtc_dst_pkg::ST_ACK_DEV;
              end else begin
                oe_d = 1'b0;
                st_d = rtc_dst_pkg::ST_IDLE;
              end
            end else if (st_q == rtc_dst_pkg::ST_WADDR) begin
              ptr_d = sh_q;
              st_d  = rtc_dst_pkg::ST_ACK_ADDR;
            end else begin
              wr_d  = 1'b1;
              wa_d  = ptr_q;
              wd_d  = sh_q;
              ptr_d = ptr_next(ptr_q);
              st_d  = rtc_dst_pkg::ST_ACK_WR;
            end
          end
        end
        rtc_dst_pkg::ST_ACK_DEV: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            if (rw_q) begin
              sh_d = rd_now;
              oe_d = ~rd_now[7];
              st_d = rtc_dst_pkg::ST_RDATA;
            end else begin
              oe_d = 1'b0;
              st_d = rtc_dst_pkg::ST_WADDR;
            end
          end
        end
        rtc_dst_pkg::ST_ACK_ADDR, rtc_dst_pkg::ST_ACK_WR: begin
          if (scl_fall) begin
            oe_d  = 1'b0;
            bit_d = 4'h0;
            st_d  = rtc_dst_pkg::ST_WDATA;
          end
        end
        rtc_dst_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (bit_q == `DST_BIT_RD_LAST) begin
              oe_d  = 1'b0;
              st_d  = rtc_dst_pkg::ST_RACK;
            end else begin
              bit_d = 4'(bit_q + 4'h1);
              sh_d  = {sh_q[6:0], 1'b0};
              oe_d  = ~sh_q[6];
            end
          end
        end
        rtc_dst_pkg::ST_RACK: begin
          if (scl_rise) begin
            nack_d = sda_s2_q;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_d = rtc_dst_pkg::ST_IDLE;
            end else begin
              ptr_d = ptr_next(ptr_q);
              sh_d  = rd_nxt;
              oe_d  = ~rd_nxt[7];
              bit_d = 4'h0;
              st_d  = rtc_dst_pkg::ST_RDATA;
            end
          end
        end
        default: begin
          st_d = rtc_dst_pkg::ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st_q   <= rtc_dst_pkg::ST_IDLE;
      bit_q  <= 4'h0;
      sh_q   <= 8'h00;
      ptr_q  <= 8'h00;
      rw_q   <= 1'b0;
      oe_q   <= 1'b0;
      nack_q <= 1'b0;
      wr_q   <= 1'b0;
      wa_q   <= 8'h00;
      wd_q   <= 8'h00;
    end else begin
      st_q   <= st_d;
      bit_q  <= bit_d;
      sh_q   <= sh_d;
      ptr_q  <= ptr_d;
      rw_q   <= rw_d;
      oe_q   <= oe_d;
      nack_q <= nack_d;
      wr_q   <= wr_d;
      wa_q   <= wa_d;
      wd_q   <= wd_d;
    end
  end

  // transition detection
  time_now_if now ();

  assign now.year  = year_i;
  assign now.month = month_i;
  assign now.date  = date_i;
  assign now.wday  = wday_i;
  assign now.hour  = hour_i;

  logic fwd_match, rev_match;

  dst_match u_fwd (
    .now     (now),
    .month_i (cfg_q[0]),
    .wday_i  (cfg_q[1]),
    .date_i  (cfg_q[2]),
    .hour_i  (cfg_q[3]),
    .hit_o   (fwd_match)
  );

  dst_match u_rev (
    .now     (now),
    .month_i (cfg_q[4]),
    .wday_i  (cfg_q[5]),
    .date_i  (cfg_q[6]),
    .hour_i  (cfg_q[7]),
    .hit_o   (rev_match)
  );

  logic dst_en, top_of_hour, fwd_hit, rev_hit, en_clear;
  logic fwd_q, fwd_d, back_q, back_d;

  always_comb begin
    dst_en      = cfg_q[0][`DST_ENABLE_BIT];
    top_of_hour = tick_i && (minute_i == 8'h00) && (second_i == 8'h00);
    fwd_hit     = dst_en && !flag_q && top_of_hour && fwd_match;
    // flag already cleared stops a second fall-back in the repeated hour
    rev_hit     = dst_en && flag_q && top_of_hour && rev_match;
    en_clear    = wr_q && (wa_q == `DST_FWD_MONTH_OFS) &&
                  !wd_q[`DST_ENABLE_BIT];
    fwd_d       = fwd_hit;
    back_d      = rev_hit;
    // only reset, the matchers and a forward-month write with enable 0 move the flag; other bus writes never do
    if (fwd_hit) begin
      flag_d = 1'b1;
    end else if (rev_hit || en_clear) begin
      flag_d = 1'b0;
    end else begin
      flag_d = flag_q;
    end
    for (int i = 0; i < `DST_REG_COUNT; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    if (wr_q && in_window(wa_q)) begin
      cfg_d[win_index(wa_q)] = wd_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      flag_q <= 1'b0;
      fwd_q  <= 1'b0;
      back_q <= 1'b0;
      for (int i = 0; i < `DST_REG_COUNT; i++) begin
        cfg_q[i] <= `DST_REG_RESET;
      end
    end else begin
      flag_q <= flag_d;
      fwd_q  <= fwd_d;
      back_q <= back_d;
      for (int i = 0; i < `DST_REG_COUNT; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  // open-drain data line only ever pulls low
  logic sda_lo_q;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sda_lo_q <= 1'b0;
    end else begin
      sda_lo_q <= 1'b0;
    end
  end

  assign sda_o             = sda_lo_q;
  assign sda_oe_o          = oe_q;
  assign hour_fwd_o        = fwd_q;
  assign hour_back_o       = back_q;
  assign forward_applied_o = flag_q;

endmodule : rtc_daylight_saving_adjust

// File: testbench/rtc_dst_sva.sv
// Purpose: port-level checks of the daylight-saving adjust block
// Assumes: one clock domain, synchronous active-low reset
// Notes:   attached by bind below the module
`timescale 1ns/1ps
module rtc_dst_sva (
  input wire logic       clk_sys_i,
  input wire logic       rstn_i,
  input wire logic       tick_i,
  input wire logic [7:0] minute_i,
  input wire logic [7:0] second_i,
  input wire logic       hour_fwd_o,
  input wire logic       hour_back_o,
  input wire logic       forward_applied_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  sequence s_mark;
    tick_i && minute_i == 8'h00 && second_i == 8'h00;
  endsequence
  sequence s_fwd_done;
    hour_fwd_o && forward_applied_o ##1 !hour_fwd_o;
  endsequence
  sequence s_back_done;
    hour_back_o && !forward_applied_o ##1 !hour_back_o;
  endsequence

  a_fwd_at_mark: assert property (
    hour_fwd_o |-> $past(tick_i) && $past(minute_i) == 8'h00
      && $past(second_i) == 8'h00)
    else $error("forward step off the hour mark");
  a_back_at_mark: assert property (
    hour_back_o |-> $past(tick_i) && $past(minute_i) == 8'h00
      && $past(second_i) == 8'h00)
    else $error("reverse step off the hour mark");
  a_flag_rise_fwd: assert property (
    $rose(forward_applied_o) |-> s_fwd_done)
    else $error("flag rose without a forward step");
  a_fwd_from_clear: assert property (
    hour_fwd_o |-> !$past(forward_applied_o))
    else $error("forward step while flag set");
  a_back_clears: assert property (
    hour_back_o |-> $past(forward_applied_o) ##0 s_back_done)
    else $error("reverse step without flag or flag kept");
  a_no_dual_step: assert property (
    !(hour_fwd_o && hour_back_o))
    else $error("both steps at once");
  a_back_once: assert property (
    hour_back_o |=> !hour_back_o [*8])
    else $error("reverse step repeated");
  a_reset_clear: assert property (
    @(posedge clk_sys_i) disable iff (1'b0)
    !rstn_i |=> !forward_applied_o)
    else $error("flag set after reset");

  c_fwd: cover property (s_mark ##1 hour_fwd_o);
endmodule : rtc_dst_sva

bind rtc_daylight_saving_adjust rtc_dst_sva chk_u (.clk_sys_i,
  .rstn_i, .tick_i, .minute_i, .second_i, .hour_fwd_o, .hour_back_o,
  .forward_applied_o);

// File: testbench/testbench.sv
// Purpose: self-checking bench for the daylight-saving adjust block
// Assumes: bench is the two-wire master; sda has a pull-up
// Notes:   calendar values partly random from a fixed seed
`timescale 1ns/1ps
`include "rtc_dst_map.svh"
`define CHK(g, e) chk(g, e)
module testbench;
  localparam logic [7:0] DEV_W = {`DST_DEV_ADDR, 1'b0};
  localparam logic [7:0] STS   = `DST_STATUS_OFS;
  logic       clk_sys_i = 1'b0;
  logic       rstn_i    = 1'b0;
  logic       scl_m     = 1'b1;
  logic       sda_m     = 1'b1;
  logic       tick_i    = 1'b0;
  logic [7:0] year_i    = 8'h24;
  logic [7:0] month_i   = 8'h01;
  logic [7:0] date_i    = 8'h01;
  logic [2:0] wday_i    = 3'h0;
  logic [7:0] hour_i    = 8'h00;
  logic [7:0] minute_i  = 8'h00;
  logic [7:0] second_i  = 8'h00;
  logic       sda_o;
  logic       sda_oe_o;
  logic       hour_fwd_o;
  logic       hour_back_o;
  logic       forward_applied_o;
  logic [7:0] cfg [8];
  int         bad_count  = 0;
  int         num_checks = 0;
  wire        sda_w = sda_m & ~sda_oe_o;

  rtc_daylight_saving_adjust dut_u (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .scl_i(scl_m), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .tick_i(tick_i), .year_i(year_i),
    .month_i(month_i), .date_i(date_i), .wday_i(wday_i),
    .hour_i(hour_i), .minute_i(minute_i), .second_i(second_i),
    .hour_fwd_o(hour_fwd_o), .hour_back_o(hour_back_o),
    .forward_applied_o(forward_applied_o));

  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] bcd(input int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction : bcd

  task automatic hp;
    repeat (5) @(posedge clk_sys_i);
  endtask : hp

  task automatic bx(input logic b, output logic r);
    sda_m <= b;
    hp();
    scl_m <= 1'b1;
    hp();
    r = sda_w;
    scl_m <= 1'b0;
    hp();
  endtask : bx

  task automatic st;
    sda_m <= 1'b1;
    hp();
    scl_m <= 1'b1;
    hp();
    sda_m <= 1'b0;
    hp();
    scl_m <= 1'b0;
    hp();
  endtask : st

  task automatic sp;
    sda_m <= 1'b0;
    hp();
    scl_m <= 1'b1;
    hp();
    sda_m <= 1'b1;
    hp();
  endtask : sp

  task automatic wb(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bx(d[i], r);
    bx(1'b1, r);
    `CHK({7'h00, r}, 8'h00);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    st();
    wb(DEV_W);
    wb(a);
    wb(d);
    sp();
  endtask : wr

  // random read, single byte closed by a master nack
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       r;
    st();
    wb(DEV_W);
    wb(a);
    st();
    wb(DEV_W | 8'h01);
    for (int i = 7; i >= 0; i--) bx(1'b1, d[i]);
    bx(1'b1, r);
    sp();
    `CHK(d, e);
    `CHK({7'h00, sda_o}, 8'h00);
  endtask : rc

  task automatic tm(input logic [7:0] y, input logic [7:0] mo,
                    input logic [7:0] d, input logic [7:0] h);
    year_i  <= y;
    month_i <= mo;
    date_i  <= d;
    hour_i  <= h;
    @(posedge clk_sys_i);
  endtask : tm

  // one tick, then count step pulses over the following cycles
  task automatic tk(input logic [7:0] ef, input logic [7:0] eb);
    logic [7:0] nf;
    logic [7:0] nb;
    nf = 8'h00;
    nb = 8'h00;
    tick_i <= 1'b1;
    @(posedge clk_sys_i);
    tick_i <= 1'b0;
    repeat (4) begin
      @(negedge clk_sys_i);
      nf += {7'h00, hour_fwd_o === 1'b1};
      nb += {7'h00, hour_back_o === 1'b1};
    end
    @(posedge clk_sys_i);
    `CHK(nf, ef);
    `CHK(nb, eb);
  endtask : tk

  initial begin
    repeat (100000) @(posedge clk_sys_i);
    bad_count++;
    test_done();
  end

  initial begin
    int dd;
    dd = int'($urandom(29));
    cfg = '{8'h84, 8'h48, 8'h00, 8'h02, 8'h10, 8'h78, 8'h00, 8'h02};
    cfg[2] = 8'($urandom());
    cfg[6] = 8'($urandom());
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    for (int a = 0; a < 8; a++) rc(`DST_FWD_MONTH_OFS + 8'(a), 8'h00);
    rc(STS, 8'h00);
    for (int a = 0; a < 8; a++) wr(`DST_FWD_MONTH_OFS + 8'(a), cfg[a]);
    for (int a = 0; a < 8; a++) rc(`DST_FWD_MONTH_OFS + 8'(a), cfg[a]);
    wr(8'h20, 8'hA5);
    rc(8'h20, 8'h00);
    wr(STS, 8'hFF);
    rc(STS, 8'h00);
    $display("test registers done");
    dd = 1 + int'($urandom_range(6));
    tm(8'h24, 8'h04, bcd(dd), 8'h03);
    tk(8'h00, 8'h00);
    tm(8'h24, 8'h04, bcd(dd), 8'h02);
    minute_i <= 8'h01;
    tk(8'h00, 8'h00);
    minute_i <= 8'h00;
    tk(8'h01, 8'h00);
    rc(STS, 8'h01 << `DST_FLAG_BIT);
    `CHK({7'h00, forward_applied_o}, 8'h01);
    tk(8'h00, 8'h00);
    tm(8'h24, 8'h10, 8'h18, 8'h02);
    tk(8'h00, 8'h00);
    dd = 25 + int'($urandom_range(6));
    tm(8'h24, 8'h10, bcd(dd), 8'h02);
    tk(8'h00, 8'h01);
    rc(STS, 8'h00);
    `CHK({7'h00, forward_applied_o}, 8'h00);
    tk(8'h00, 8'h00);
    $display("test forward reverse done");
    dd = 1 + int'($urandom_range(6));
    tm(8'h25, 8'h04, bcd(dd), 8'h02);
    tk(8'h01, 8'h00);
    wr(`DST_FWD_MONTH_OFS, 8'h04);
    rc(STS, 8'h00);
    tk(8'h00, 8'h00);
    wr(`DST_FWD_DATE_OFS, 8'h15);
    wr(`DST_FWD_MONTH_OFS, 8'h84);
    wday_i <= 3'h3;
    tm(8'h25, 8'h04, 8'h15, 8'h02);
    tk(8'h00, 8'h00);
    `CHK({7'h00, forward_applied_o}, 8'h00);
    wr(`DST_FWD_WDAY_OFS, 8'h00);
    tk(8'h01, 8'h00);
    $display("test year and date mode done");
    rstn_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rc(STS, 8'h00);
    rc(`DST_FWD_MONTH_OFS, 8'h00);
    $display("test second reset done");
    test_done();
  end
endmodule : testbench
